// ---- dv/eprom_program_verify_lock_tb.sv ----
// Self-checking bench for erase, verify, refused strobe and fetch gating.
`timescale 1ns/10ps
module eprom_program_verify_lock_tb;
   logic       i_clk, i_sys_rst, i_erase, i_ext_fetch_req, done_seen;
   logic       rst_pin, store_pin, strobe_pin, vpp_pin;
   logic [7:0] port1, port2, port0, o_port0, o_port0_oe;
   logic       o_lock, o_ext_fetch_ok, o_write_done;
   int         err_count = 0;
   int         cmp_count = 0;
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk; // Runs through every strobe.
   end
   // Strobe width scaled down in cycles so that full writes fit the run.
   localparam int STB_CYC = 1000;
   eprom_program_verify_lock #(.STROBE_CYCLES(STB_CYC)) u_dut (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .i_reset_pin(rst_pin), .i_program_store_strobe_pin(store_pin),
      .i_latch_program_strobe_pin(strobe_pin),
      .i_external_access_vpp_pin(vpp_pin), .i_port1(port1), .i_port2(port2),
      .i_port0(port0), .i_erase(i_erase), .i_ext_fetch_req(i_ext_fetch_req),
      .o_port0(o_port0), .o_port0_oe(o_port0_oe), .o_lock(o_lock),
      .o_ext_fetch_ok(o_ext_fetch_ok), .o_write_done(o_write_done));
   eprom_programmer_model u_prog (.i_clk(i_clk), .i_dev_port0(o_port0),
      .i_dev_port0_oe(o_port0_oe), .o_reset_pin(rst_pin),
      .o_store_pin(store_pin), .o_strobe_pin(strobe_pin),
      .o_vpp_pin(vpp_pin), .o_port1(port1), .o_port2(port2),
      .o_port0(port0));
   // Latch any done pulse so a one-cycle event is never missed.
   always @(posedge i_clk) if (o_write_done === 1'b1) done_seen <= 1'b1;
   task automatic check(input logic [7:0] seen, exp, input string msg);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask : check
   task automatic test_done();
      if (err_count == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : test_done
   task automatic t_erase();
      @(posedge i_clk) i_erase <= 1'b1;
      repeat (4) @(posedge i_clk);
      i_erase <= 1'b0;
      repeat (6) @(posedge i_clk);
      check({7'h00, o_lock}, 8'h00, "lock after erase");
   endtask : t_erase
   task automatic t_read(input logic [11:0] a, input logic [7:0] exp);
      u_prog.set_levels(a, 1'b0, 1'b0, 1'b0, 8'h00);
      repeat (10) @(posedge i_clk);
      check(o_port0, exp, "verify byte");
      check(o_port0_oe, 8'hFF, "verify drive");
   endtask : t_read
   // A strobe far below the minimum width must not write anything.
   task automatic t_short();
      done_seen = 1'b0;
      u_prog.set_levels(12'h123, 1'b1, 1'b0, 1'b1, 8'h00);
      repeat (5) @(posedge i_clk);
      u_prog.strobe(200);
      repeat (20) @(posedge i_clk);
      check({7'h00, done_seen}, 8'h00, "short strobe wrote");
      check(o_port0_oe, 8'h00, "drive outside verify");
      t_read(12'h123, 8'hFF);
   endtask : t_short
   // One full strobe with vpp up; a completed strobe must report done.
   task automatic t_write(input logic [11:0] a, input logic md,
                          input logic [7:0] d);
      u_prog.set_levels(a, 1'b1, md, 1'b1, d);
      repeat (5) @(posedge i_clk);
      done_seen = 1'b0;
      u_prog.strobe(STB_CYC + 100);
      repeat (20) @(posedge i_clk);
      check({7'h00, done_seen}, 8'h01, "strobe not taken");
   endtask : t_write
   // Lock with junk on the ports, then readout and external fetch must stop.
   task automatic t_lock(input logic [11:0] a);
      t_write(12'hA5A, 1'b1, 8'h00);
      check({7'h00, o_lock}, 8'h01, "lock not set");
      u_prog.set_levels(a, 1'b0, 1'b0, 1'b0, 8'h00);
      repeat (10) @(posedge i_clk);
      check(o_port0_oe, 8'h00, "readout while locked");
      check(o_port0, 8'h00, "data while locked");
      @(posedge i_clk) i_ext_fetch_req <= 1'b1;
      repeat (4) @(posedge i_clk);
      check({7'h00, o_ext_fetch_ok}, 8'h00, "fetch while locked");
      i_ext_fetch_req <= 1'b0;
   endtask : t_lock
   task automatic t_fetch();
      @(posedge i_clk) i_ext_fetch_req <= 1'b1;
      repeat (4) @(posedge i_clk);
      check({7'h00, o_ext_fetch_ok}, 8'h01, "fetch denied");
      i_ext_fetch_req <= 1'b0;
      repeat (4) @(posedge i_clk);
      check({7'h00, o_ext_fetch_ok}, 8'h00, "fetch stuck");
   endtask : t_fetch
   initial begin
      i_sys_rst       = 1'b1;
      i_erase         = 1'b0;
      i_ext_fetch_req = 1'b0;
      done_seen       = 1'b0;
      repeat (20) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      repeat (5) @(posedge i_clk);
      t_erase();
      t_read(12'h000, 8'hFF);
      t_read(12'hFFF, 8'hFF);
      t_read(12'h5A5, 8'hFF);
      t_short();
      t_write(12'h2C4, 1'b0, 8'h3C);
      t_read(12'h2C4, 8'h3C);
      t_fetch();
      t_lock(12'h2C4);
      t_erase();
      t_read(12'h2C4, 8'hFF);
      t_fetch();
      test_done();
   end
   // The tests need about 2600 cycles; this limit cuts a hang short.
   initial begin
      repeat (20000) @(posedge i_clk);
      err_count++;
      test_done();
   end
endmodule : eprom_program_verify_lock_tb

// ---- dv/eprom_programmer_model.sv ----
// Programmer model that drives the mode pins, address and code byte.
`timescale 1ns/10ps
module eprom_programmer_model (
   input  wire logic       i_clk,
   input  wire logic [7:0] i_dev_port0,
   input  wire logic [7:0] i_dev_port0_oe,
   output logic            o_reset_pin,
   output logic            o_store_pin,
   output logic            o_strobe_pin,
   output logic            o_vpp_pin,
   output logic [7:0]      o_port1,
   output logic [7:0]      o_port2,
   output logic [7:0]      o_port0
);
   logic [7:0] drv_r = 8'h00;
   logic       drv_en_r = 1'b0;
   // Pull-ups hold a released port 0 line high, never at a stale value.
   assign o_port0 = drv_en_r ? drv_r : (i_dev_port0 | ~i_dev_port0_oe);
   initial begin
      o_reset_pin  = 1'b0;
      o_store_pin  = 1'b0;
      o_strobe_pin = 1'b1;
      o_vpp_pin    = 1'b0;
      o_port1      = 8'h00;
      o_port2      = 8'h00;
   end
   // Upper port 2 bits 5 and 4 are set on purpose, since they are ignored.
   task automatic set_levels(input logic [11:0] a, input logic en, md, vp,
                             input logic [7:0] d);
      @(posedge i_clk);
      o_reset_pin <= 1'b1;
      o_port1     <= a[7:0];
      o_port2     <= {en, md, 2'b11, a[11:8]};
      o_vpp_pin   <= vp;
      drv_r       <= d;
      drv_en_r    <= en;
   endtask : set_levels
   task automatic strobe(input int n);
      @(posedge i_clk);
      o_strobe_pin <= 1'b0;
      repeat (n) @(posedge i_clk);
      o_strobe_pin <= 1'b1;
   endtask : strobe
endmodule : eprom_programmer_model

// ---- dv/eprom_pv_asserts.sv ----
// Checker for the lock, fetch and readout behaviour at the block's ports.
`timescale 1ns/10ps
module eprom_pv_asserts (
   input wire logic       i_clk,
   input wire logic       i_sys_rst,
   input wire logic       i_erase,
   input wire logic       i_ext_fetch_req,
   input wire logic [7:0] o_port0_oe,
   input wire logic       o_lock,
   input wire logic       o_ext_fetch_ok,
   input wire logic       o_write_done
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   // A set lock must hide the array from every outside reader.
   lock_oe_a: assert property (o_lock |-> o_port0_oe == 8'h00)
      else $error("port 0 driven while locked");
   lock_fetch_a: assert property (o_lock |-> !o_ext_fetch_ok)
      else $error("external fetch granted while locked");
   fetch_req_a: assert property (!i_ext_fetch_req |=> !o_ext_fetch_ok)
      else $error("fetch granted without request");
   fetch_cause_a: assert property ($rose(o_ext_fetch_ok) |->
      $past(i_ext_fetch_req) && !o_lock)
      else $error("fetch grant without unlocked request");
   erase_clear_a: assert property (i_erase |=> ##1 !o_lock)
      else $error("lock survives erase");
   lock_fall_a: assert property ($fell(o_lock) |-> $past(i_erase, 2))
      else $error("lock cleared without erase");
   oe_whole_a: assert property (o_port0_oe inside {8'h00, 8'hFF})
      else $error("port 0 enable split");
   done_pulse_a: assert property (o_write_done |=> !o_write_done)
      else $error("write done longer than one cycle");
   cover property (o_port0_oe == 8'hFF);
   cover property (i_erase ##1 !i_erase);
   cover property (o_ext_fetch_ok);
   cover property (o_write_done);
   cover property (o_lock);
endmodule : eprom_pv_asserts
bind eprom_program_verify_lock eprom_pv_asserts u_asserts (.i_clk,
   .i_sys_rst, .i_erase, .i_ext_fetch_req, .o_port0_oe, .o_lock,
   .o_ext_fetch_ok, .o_write_done);

// ---- hw/eprom_program_verify_lock.sv ----
// Program memory with program, verify and security lock pin protocol.
//
// What the document requires
// RQ1: The programmer keeps the device clock at 4 to 6 MHz while programming; the strobe timing assumes a 25 MHz clock.
// RQ2: The programmer places the address on port 1 and port 2 lines 0 to 3.
// RQ3: The programmer presents the code byte on port 0.
// RQ4: Program mode is reset high, store pin low, vpp high, enable high, mode low.
// RQ5: The programmer pulses the latch strobe low for 50 ms to write a byte.
// RQ6: The programmer raises vpp only around the strobe pulse.
// RQ7: Readout for verification is allowed only while the lock is clear.
// RQ8: For verify the programmer supplies the address and verify levels.
// RQ9: Verify is program setup with enable low, strobe high, vpp at logic high; the code does not check vpp in verify.
// RQ10: In verify the addressed byte is driven out on port 0.
// RQ11: The lock is set like programming but with the mode line high.
// RQ12: While setting the lock, port 0, port 1 and port 2 low lines are ignored.
// RQ13: While locked, readout and further programming are refused.
// RQ14: While locked, fetches from external program memory are blocked.
// RQ15: Only full erasure clears the lock and restores all functions.
// RQ16: After erasure every location reads as all ones.
// RQ17: Address and byte are captured at strobe start and held for the write.
`timescale 1ns/10ps
`include "eprom_pv_consts.svh"
module eprom_program_verify_lock #(
   // Strobe width in clock cycles; a bench may shorten it to keep runs brief.
   parameter int unsigned STROBE_CYCLES = `STROBE_CYC
) (
   input  wire logic                 i_clk,
   input  wire logic                 i_sys_rst,
   input  wire logic                 i_reset_pin,
   input  wire logic                 i_program_store_strobe_pin,
   input  wire logic                 i_latch_program_strobe_pin,
   input  wire logic                 i_external_access_vpp_pin,
   input  wire logic [7:0]           i_port1,
   input  wire logic [7:0]           i_port2,
   input  wire logic [7:0]           i_port0,
   input  wire logic                 i_erase,
   input  wire logic                 i_ext_fetch_req,
   output logic      [7:0]           o_port0,
   output logic      [7:0]           o_port0_oe,
   output logic                      o_lock,
   output logic                      o_ext_fetch_ok,
   output logic                      o_write_done
);
   import eprom_pv_pkg::*;

   // Pins needing synchronising: control pins plus the enable and mode lines.
   localparam int NSYNC = 6;
   logic [NSYNC-1:0] raw_pins;
   logic [NSYNC-1:0] pins;
   assign raw_pins = {i_reset_pin, i_program_store_strobe_pin,
                      i_latch_program_strobe_pin, i_external_access_vpp_pin,
                      i_port2[`ENABLE_BIT], i_port2[`MODE_BIT]};

   genvar g;
   generate
      for (g = 0; g < NSYNC; g++) begin : g_sync
         pin_sync3 u_sync (
            .i_clk     (i_clk),
            .i_sys_rst (i_sys_rst),
            .i_pin     (raw_pins[g]),
            .o_level   (pins[g])
         );
      end
   endgenerate

   logic rst_s;
   logic store_s;
   logic strobe_s;
   logic vpp_s;
   logic enable_s;
   logic mode_s;
   assign {rst_s, store_s, strobe_s, vpp_s, enable_s, mode_s} = pins;

   // Address and data pins come from the programmer's own timing, so each
   // bus passes three flip-flops and a new word counts only once stages two
   // and three agree; a word caught while its bits settle waits a cycle.
   addr_t addr_s1_r;
   addr_t addr_s2_r;
   addr_t addr_s3_r;
   addr_t addr_r;
   byte_t data_s1_r;
   byte_t data_s2_r;
   byte_t data_s3_r;
   byte_t data_r;

   // Address word: port 1 is the low byte, port 2 lines 0 to 3 the top.
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         addr_s1_r <= 12'h000;
         addr_s2_r <= 12'h000;
         addr_s3_r <= 12'h000;
         addr_r    <= 12'h000;
      end else begin
         addr_s1_r <= {i_port2[`ADDR_HI_MSB:`ADDR_HI_LSB], i_port1}; // [RQ2]
         addr_s2_r <= addr_s1_r;
         addr_s3_r <= addr_s2_r;
         if (addr_s2_r == addr_s3_r) begin
            addr_r <= addr_s3_r;
         end
      end
   end

   // Code byte on port 0, filtered in the same way as the address.
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         data_s1_r <= 8'h00;
         data_s2_r <= 8'h00;
         data_s3_r <= 8'h00;
         data_r    <= 8'h00;
      end else begin
         data_s1_r <= i_port0; // [RQ3]
         data_s2_r <= data_s1_r;
         data_s3_r <= data_s2_r;
         if (data_s2_r == data_s3_r) begin
            data_r <= data_s3_r;
         end
      end
   end

   // Common setup levels; vpp high stands for programming voltage present.
   function automatic logic setup_ok(input logic r, input logic s);
      setup_ok = r & ~s;
   endfunction : setup_ok

   logic pgm_mode;
   logic lock_mode;
   logic verify_mode;
   assign pgm_mode    = setup_ok(rst_s, store_s) & enable_s & ~mode_s; // [RQ4]
   assign lock_mode   = setup_ok(rst_s, store_s) & enable_s & mode_s;  // [RQ11]
   assign verify_mode = setup_ok(rst_s, store_s) & ~enable_s & ~mode_s
                        & strobe_s; // [RQ9]

   // Array storage; contents survive reset since the cells are nonvolatile.
   byte_t mem [`MEM_DEPTH];
   logic  lock_r;

   pgm_state_e       state_r;
   pgm_state_e       state_nxt;
   logic [`CNT_W-1:0] cnt_r;
   addr_t            wr_addr_r;
   byte_t            wr_data_r;
   logic             wr_lock_r;

   localparam logic [`CNT_W-1:0] STROBE_LIM = `CNT_W'(STROBE_CYCLES);

   // Falling edge of the filtered strobe. The previous level resets low like
   // the synchroniser, so leaving reset never fakes a falling strobe, and a
   // strobe already low when the levels settle is not taken as a pulse.
   logic strobe_prev_r;
   logic strobe_fell;

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         strobe_prev_r <= 1'b0;
      end else begin
         strobe_prev_r <= strobe_s;
      end
   end

   assign strobe_fell = strobe_prev_r & ~strobe_s;

   // Strobe sequencing: armed on a falling strobe, committed at the rise.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (strobe_fell & vpp_s & (pgm_mode | lock_mode)) begin
               state_nxt = ST_ARMED;
            end
         end
         ST_ARMED: begin
            if (strobe_s | ~vpp_s) begin
               state_nxt = ST_IDLE; // Pulse ended early or vpp lost: no write.
            end else if (cnt_r >= STROBE_LIM) begin
               state_nxt = ST_WRITE;
            end
         end
         ST_WRITE: begin
            if (strobe_s) begin
               state_nxt = ST_DONE;
            end
         end
         ST_DONE:  state_nxt = ST_IDLE;
         default:  state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Pulse width counter, cleared while not armed.
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cnt_r <= '0;
      end else if (state_r == ST_ARMED) begin
         if (cnt_r < STROBE_LIM) begin
            cnt_r <= cnt_r + `CNT_W'(1);
         end
      end else begin
         cnt_r <= '0;
      end
   end

   // Capture target and byte as the strobe falls and hold them to the end.
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wr_addr_r <= 12'h000;
         wr_data_r <= 8'h00;
      end else if (state_r == ST_IDLE && state_nxt == ST_ARMED) begin
         wr_addr_r <= addr_r;     // [RQ17]
         wr_data_r <= data_r;     // [RQ17]
      end
   end

   // Kind of write, kept apart from the ports so that a lock strobe never
   // touches the array, whatever the ports show at the time.
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wr_lock_r <= 1'b0;
      end else if (state_r == ST_IDLE && state_nxt == ST_ARMED) begin
         wr_lock_r <= lock_mode;  // Ports ignored for the lock. [RQ12]
      end
   end

   // Array write strobe: a completed program pulse while unlocked. A lock
   // strobe never writes the array, and a locked part refuses programming.
   logic mem_wr_en;
   assign mem_wr_en = (state_r == ST_DONE) & ~wr_lock_r & ~lock_r; // [RQ13]

   // Array write and erase. A write only clears bits, as EPROM cells do.
   always_ff @(posedge i_clk) begin
      if (i_erase) begin
         for (int i = 0; i < `MEM_DEPTH; i++) begin
            mem[i] <= `ERASED_BYTE; // [RQ16]
         end
      end else if (mem_wr_en) begin
         mem[wr_addr_r] <= mem[wr_addr_r] & wr_data_r; // [RQ13]
      end
   end

   // Lock bit: set by the lock strobe, cleared only by erase. Not reset.
   always_ff @(posedge i_clk) begin
      if (i_erase) begin
         lock_r <= 1'b0; // [RQ15]
      end else if (state_r == ST_DONE && wr_lock_r) begin
         lock_r <= 1'b1; // [RQ11]
      end
   end

   // Readout is allowed only in verify mode with the lock clear; a locked
   // part, or one whose lock is still unknown, keeps port 0 released.
   logic rd_en;
   assign rd_en = verify_mode & ~lock_r; // [RQ7] [RQ13]

   // Verify data for the addressed location; zero while released.
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_port0 <= 8'h00;
      end else if (rd_en) begin
         o_port0 <= mem[addr_r]; // [RQ10]
      end else begin
         o_port0 <= 8'h00;
      end
   end

   // Port 0 drive enable, all lines together, high only while reading.
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_port0_oe <= 8'h00;
      end else if (rd_en) begin
         o_port0_oe <= 8'hFF; // [RQ10]
      end else begin
         o_port0_oe <= 8'h00; // [RQ13]
      end
   end

   // Lock state as seen outside. The cells power up unknown in simulation,
   // so only a lock that is known to be set shows; an erase defines it.
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_lock <= 1'b0;
      end else begin
         o_lock <= (lock_r === 1'b1);
      end
   end

   // External fetch grant follows the request unless the lock is set.
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_ext_fetch_ok <= 1'b0;
      end else begin
         o_ext_fetch_ok <= i_ext_fetch_req & (lock_r !== 1'b1); // [RQ14]
      end
   end

   // One-cycle pulse in the cycle after each completed strobe, also one refused because the lock is set.
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_write_done <= 1'b0;
      end else begin
         o_write_done <= (state_r == ST_DONE);
      end
   end
endmodule : eprom_program_verify_lock

// ---- hw/pin_sync3.sv ----
// Three-stage pin synchroniser that accepts a change once stages agree.
`timescale 1ns/10ps
module pin_sync3 (
   input  wire logic i_clk,
   input  wire logic i_sys_rst,
   input  wire logic i_pin,
   output logic      o_level
);
   logic s1_r;
   logic s2_r;
   logic s3_r;

   // Stage one feeds only stage two; agreement of two and three filters.
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         s1_r    <= 1'b0;
         s2_r    <= 1'b0;
         s3_r    <= 1'b0;
         o_level <= 1'b0;
      end else begin
         s1_r <= i_pin;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            o_level <= s3_r;
         end
      end
   end
endmodule : pin_sync3

// ---- inc/eprom_pv_consts.svh ----
// Constants for the program memory program, verify and lock block.
`ifndef EPROM_PV_CONSTS_SVH
`define EPROM_PV_CONSTS_SVH
`define ADDR_W          12
`define DATA_W          8
`define MEM_DEPTH       4096
`define ERASED_BYTE     8'hFF
`define CLK_HZ          25000000
`define STROBE_MIN_MS   45
`define STROBE_CYC      ((`STROBE_MIN_MS * (`CLK_HZ / 1000)))
`define CNT_W           24
`define ADDR_HI_LSB     0
`define ADDR_HI_MSB     3
`define ENABLE_BIT      7
`define MODE_BIT        6
`endif

// ---- inc/eprom_pv_pkg.sv ----
// Types for the program memory program, verify and lock block.
package eprom_pv_pkg;
   typedef logic [11:0] addr_t;
   typedef logic [7:0]  byte_t;
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_ARMED = 4'b0010,
      ST_WRITE = 4'b0100,
      ST_DONE  = 4'b1000
   } pgm_state_e;
endpackage : eprom_pv_pkg
